// >>> rtl/supply_thermal_supervisor.sv
// supply and thermal supervisor: zone B reaction, fault shutdown, die throttle, ADC polling
// assumes comparator flags and converter results already synchronous to clk
//
// Functional notes
// - zone B entry interrupts, drives disable/throttle
// - zone B exit interrupts, releases non-sticky outputs
// - under/over voltage shuts down without host
// - over-voltage holds off until flag gone
// - under-voltage holds off until supply valid
// - no interrupt for under/over voltage
// - under/over voltage filtered 100us
// - die pre-alarm over 100us asserts throttle
// - throttle released after 500us quiet
// - die over-temperature 100us forces shutdown
// - zone A/B throttle enable bits
// - throttle status bit mirrors output level
// - poll enable runs timed converter polling
// - active rate codes off,1s,4s,32s
// - idle rate bit off or 32s
// - monitoring only in sleep, idle or full-on
// - sensor enable gates polling and alerts
// - smaller code means hotter
// - two alerts, critical, hysteresis, status bits
// - critical level holds threshold bits 8:1
// - alert clears past threshold plus hysteresis
// - first alert policy enables throttle
`timescale 1ns/100ps
module supply_thermal_supervisor
	import supply_thermal_supervisor_pkg::*;
#(
	parameter int FILT_CYCLES = FILT_CYC,
	parameter int RELEASE_CYCLES = RELEASE_CYC,
	parameter int TICK_CYCLES = TICK_MS_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// platform
	input wire power_e powerState,
	input wire flags_s flags,
	// converter
	output logic convStart,
	output logic [1:0] convChannel,
	input wire sample_s sample,
	// outputs
	output logic processor_throttle_n,
	output logic zone_b_disable_output,
	output logic supply_monitor_irq,
	output logic shutdownReq
);
	logic [7:0] monCtlA, monCtlB, throtBeh, zoneBCtl, sensorEn;
	logic [7:0] sys0A0H, sys0A0L, sys0A1H, sys0A1L, sys0Crit, sys1A0H, sys1A0L;
	logic zbIrq, sumIrq, zbLevel, zbPrev, zbHeld, shutdown, ovHold, uvHold;
	logic uvOk, ovOk, warmOk, hotOk, dieThrot;
	logic [16:0] uvCnt, ovCnt, warmCnt, hotCnt;
	logic [16:0] relCnt;
	logic [NCH-1:0] a0St, a1St, critSt;
	logic [16:0] tickCnt;
	logic [9:0] msCnt;
	logic secTick;
	logic [5:0] age [NCH];
	logic [1:0] ch;

	function automatic logic [5:0] rate_period(input logic [1:0] code, input logic idleBit, input logic idle);
		if (idle)
			return idleBit ? PERIOD_32S : 6'h00;
		unique case (code)
			2'b00: return 6'h00;
			2'b01: return PERIOD_1S;
			2'b10: return PERIOD_4S;
			2'b11: return PERIOD_32S;
		endcase
	endfunction : rate_period

	// filter: output rises only after a steady run, drops as soon as the input drops
	function automatic logic [16:0] filt_next(input logic [16:0] cnt, input logic in, input int lim);
		if (!in)
			return 17'h0;
		if (cnt < 17'(lim))
			return cnt + 17'h1;
		return cnt;
	endfunction : filt_next

	// register writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			monCtlA <= RST_MON_CTL_A;
			monCtlB <= RST_MON_CTL_B;
			throtBeh <= RST_ZERO;
			zoneBCtl <= RST_ZERO;
			sensorEn <= RST_ZERO;
			sys0A0H <= RST_ZERO;
			sys0A0L <= RST_ZERO;
			sys0A1H <= RST_ZERO;
			sys0A1L <= RST_ZERO;
			sys0Crit <= RST_ZERO;
			sys1A0H <= RST_ZERO;
			sys1A0L <= RST_ZERO;
		end else begin
			zoneBCtl[F_ZB_CLEAR] <= 1'b0;
			if (regWrite) begin
				unique case (regAddr)
					OFF_MON_CTL_A: monCtlA <= {1'b0, regWdata[6:0]};
					OFF_MON_CTL_B: monCtlB <= {5'h00, regWdata[2:0]};
					OFF_THROT_BEH: throtBeh <= {6'h00, regWdata[1:0]};
					OFF_ZONE_B_CTL: zoneBCtl <= {5'h00, regWdata[2:0]};
					OFF_SENSOR_EN: sensorEn <= {5'h00, regWdata[2:0]};
					OFF_SYS0_A0H: sys0A0H <= regWdata;
					OFF_SYS0_A0L: sys0A0L <= regWdata;
					OFF_SYS0_A1H: sys0A1H <= {1'b0, regWdata[6:0]};
					OFF_SYS0_A1L: sys0A1L <= regWdata;
					OFF_SYS0_CRIT: sys0Crit <= regWdata;
					OFF_SYS1_A0H: sys1A0H <= regWdata;
					OFF_SYS1_A0L: sys1A0L <= regWdata;
					default: ;
				endcase
			end
		end
	end

	// read mux; status is live
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			regRdata <= 8'h00;
		else if (regRead) begin
			unique case (regAddr)
				OFF_MON_CTL_A: regRdata <= monCtlA;
				OFF_MON_CTL_B: regRdata <= monCtlB;
				OFF_THROT_BEH: regRdata <= {5'h00, processor_throttle_n, throtBeh[1:0]};
				OFF_ZONE_B_CTL: regRdata <= {3'h0, sumIrq, zbIrq, 1'b0, zoneBCtl[1:0]};
				OFF_STATUS: regRdata <= {critSt[1:0], a1St[1:0], a0St[1:0], zbLevel, shutdown};
				OFF_SENSOR_EN: regRdata <= sensorEn;
				OFF_SYS0_A0H: regRdata <= sys0A0H;
				OFF_SYS0_A0L: regRdata <= sys0A0L;
				OFF_SYS0_A1H: regRdata <= sys0A1H;
				OFF_SYS0_A1L: regRdata <= sys0A1L;
				OFF_SYS0_CRIT: regRdata <= sys0Crit;
				OFF_SYS1_A0H: regRdata <= sys1A0H;
				OFF_SYS1_A0L: regRdata <= sys1A0L;
				default: regRdata <= 8'h00;
			endcase
		end
	end

	// zone B: flag arrives already debounced by the comparator front end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zbPrev <= 1'b0;
			zbIrq <= 1'b0;
			sumIrq <= 1'b0;
			zbHeld <= 1'b0;
		end else begin
			zbPrev <= flags.zoneB;
			// set wins over the host clear in the same cycle
			if (flags.zoneB != zbPrev) begin
				zbIrq <= 1'b1;
				sumIrq <= 1'b1;
			end else if (regWrite && regAddr == OFF_ZONE_B_CTL) begin
				if (regWdata[F_ZB_IRQ])
					zbIrq <= 1'b0;
				if (regWdata[F_SUM_IRQ])
					sumIrq <= 1'b0;
			end
			if (flags.zoneB)
				zbHeld <= 1'b1;
			else if (!zoneBCtl[F_ZB_STICKY] || zoneBCtl[F_ZB_CLEAR])
				zbHeld <= 1'b0;
		end
	end
	assign zbLevel = flags.zoneB || zbHeld;
	assign supply_monitor_irq = sumIrq;

	// fault filters
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			uvCnt <= 17'h0;
			ovCnt <= 17'h0;
			warmCnt <= 17'h0;
			hotCnt <= 17'h0;
		end else begin
			uvCnt <= filt_next(uvCnt, flags.underVolt, FILT_CYCLES);
			ovCnt <= filt_next(ovCnt, flags.overVolt, FILT_CYCLES);
			warmCnt <= filt_next(warmCnt, flags.dieWarm, FILT_CYCLES);
			hotCnt <= filt_next(hotCnt, flags.dieHot, FILT_CYCLES);
		end
	end
	assign uvOk = uvCnt == 17'(FILT_CYCLES);
	assign ovOk = ovCnt == 17'(FILT_CYCLES);
	assign warmOk = warmCnt == 17'(FILT_CYCLES);
	assign hotOk = hotCnt == 17'(FILT_CYCLES);

	// shutdown holds: no host involvement, no interrupt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovHold <= 1'b0;
			uvHold <= 1'b0;
		end else begin
			if (ovOk)
				ovHold <= 1'b1;
			else if (!flags.overVolt)
				ovHold <= 1'b0;
			if (uvOk || hotOk || (critSt[CH_DIE] && !monCtlA[F_POLL_EN]))
				uvHold <= 1'b1;
			else if (flags.supplyValid)
				uvHold <= 1'b0;
		end
	end
	assign shutdown = ovHold || uvHold;
	assign shutdownReq = shutdown;

	// die throttle with minimum hold
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dieThrot <= 1'b0;
			relCnt <= 17'h0;
		end else if (warmOk) begin
			dieThrot <= 1'b1;
			relCnt <= 17'h0;
		end else if (dieThrot) begin
			if (flags.dieWarm)
				relCnt <= 17'h0;
			else if (relCnt == 17'(RELEASE_CYCLES - 1))
				dieThrot <= 1'b0;
			else
				relCnt <= relCnt + 17'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			processor_throttle_n <= 1'b1;
			zone_b_disable_output <= 1'b0;
		end else begin
			processor_throttle_n <= !(dieThrot
				|| (zbLevel && throtBeh[F_THR_ZB_EN])
				|| (flags.zoneA && throtBeh[F_THR_ZA_EN])
				|| (a0St[CH_SYS] && sys0A0H[F_APOL] && sensorEn[CH_SYS]));
			zone_b_disable_output <= zbLevel && zoneBCtl[F_ZB_DIS_EN];
		end
	end

	// seconds timebase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCnt <= 17'h0;
			msCnt <= 10'h0;
			secTick <= 1'b0;
		end else begin
			secTick <= 1'b0;
			if (tickCnt == 17'(TICK_CYCLES - 1)) begin
				tickCnt <= 17'h0;
				if (msCnt == 10'(SEC_MS - 1)) begin
					msCnt <= 10'h0;
					secTick <= 1'b1;
				end else
					msCnt <= msCnt + 10'h1;
			end else
				tickCnt <= tickCnt + 17'h1;
		end
	end

	// poll scheduler: one request per channel per period, lowest channel first
	logic monActive, idle;
	logic [5:0] per [NCH];
	assign idle = powerState == PWR_IDLE;
	assign monActive = monCtlA[F_POLL_EN] && (powerState == PWR_SLEEP || powerState == PWR_ON || idle);
	assign per[CH_SYS] = rate_period(monCtlA[F_SYS_RATE_A+:2], monCtlA[F_SYS_RATE_I], idle);
	assign per[CH_BAT] = rate_period(monCtlA[F_BAT_RATE_A+:2], monCtlA[F_BAT_RATE_I], idle);
	assign per[CH_DIE] = rate_period(monCtlB[F_DIE_RATE_A+:2], monCtlB[F_DIE_RATE_I], idle);

	logic [NCH-1:0] due, pending, next_pending;
	logic [1:0] pick;
	logic issue, convBusy;

	always_comb begin
		due = '0;
		for (int i = 0; i < NCH; i++)
			due[i] = secTick && monActive && per[i] != 6'h00 && sensorEn[i] && age[i] + 6'h1 >= per[i];
		next_pending = monActive ? (pending | due) : '0;
		pick = 2'b00;
		for (int i = NCH - 1; i >= 0; i--)
			if (next_pending[i])
				pick = 2'(i);
	end
	// one conversion in flight; channels due on one tick wait their turn, none is lost
	assign issue = !convBusy && !convStart && (|next_pending);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++)
				age[i] <= 6'h0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (secTick && monActive && per[i] != 6'h00 && sensorEn[i])
					age[i] <= due[i] ? 6'h0 : age[i] + 6'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending <= '0;
			convBusy <= 1'b0;
			convStart <= 1'b0;
			convChannel <= 2'b00;
		end else begin
			convStart <= issue;
			if (issue) begin
				convChannel <= pick;
				pending <= next_pending & ~(NCH'(1) << pick);
			end else
				pending <= next_pending;
			// a converter that never answers stalls polling
			if (convStart)
				convBusy <= 1'b1;
			else if (sample.valid)
				convBusy <= 1'b0;
		end
	end

	// threshold compare; system channel 0 carries full thresholds here
	logic [9:0] a0Thr, a1Thr, critThr;
	logic [3:0] a0Hy, a1Hy;
	assign a0Thr = {sys0A0H[1:0], sys0A0L};
	assign a1Thr = {sys0A1H[1:0], sys0A1L};
	assign a0Hy = sys0A0H[F_HYST+:4];
	assign a1Hy = sys0A1H[F_HYST+:4];
	assign critThr = {1'b0, sys0Crit, 1'b0};
	assign ch = sample.channel;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a0St <= '0;
			a1St <= '0;
			critSt <= '0;
		end else if (sample.valid && ch == 2'(CH_SYS) && sensorEn[CH_SYS]) begin
			// smaller code is hotter
			if (sys0A0H[F_AEN] && sample.code < a0Thr)
				a0St[CH_SYS] <= 1'b1;
			else if (!sys0A0H[F_AEN] || 11'(sample.code) > 11'(a0Thr) + 11'(a0Hy))
				a0St[CH_SYS] <= 1'b0;
			if (sys0A1H[F_AEN] && sample.code < a1Thr)
				a1St[CH_SYS] <= 1'b1;
			else if (!sys0A1H[F_AEN] || 11'(sample.code) > 11'(a1Thr) + 11'(a1Hy))
				a1St[CH_SYS] <= 1'b0;
			critSt[CH_SYS] <= sample.code < critThr;
		end
	end
endmodule : supply_thermal_supervisor

// >>> rtl/supply_thermal_supervisor_pkg.sv
// constants, field layouts and carrier types for the supply and thermal supervisor
// assumes a 125 MHz core clock and an 8-bit register port with byte offsets
package supply_thermal_supervisor_pkg;
	localparam int CLK_MHZ = 125;
	// register offsets
	localparam logic [7:0] OFF_MON_CTL_A = 8'h8e;
	localparam logic [7:0] OFF_MON_CTL_B = 8'h8f;
	localparam logic [7:0] OFF_SYS0_A0H = 8'h94;
	localparam logic [7:0] OFF_SYS0_A0L = 8'h95;
	localparam logic [7:0] OFF_SYS0_A1H = 8'h96;
	localparam logic [7:0] OFF_SYS0_A1L = 8'h97;
	localparam logic [7:0] OFF_SYS0_CRIT = 8'h98;
	localparam logic [7:0] OFF_SYS1_A0H = 8'h99;
	localparam logic [7:0] OFF_SYS1_A0L = 8'h9a;
	localparam logic [7:0] OFF_THROT_BEH = 8'hba;
	localparam logic [7:0] OFF_ZONE_B_CTL = 8'hbd;
	localparam logic [7:0] OFF_STATUS = 8'hbe;
	localparam logic [7:0] OFF_SENSOR_EN = 8'hbf;
	// reset values
	localparam logic [7:0] RST_MON_CTL_A = 8'h15;
	localparam logic [7:0] RST_MON_CTL_B = 8'h02;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// control A fields
	localparam int F_POLL_EN = 0;
	localparam int F_BAT_RATE_A = 1;
	localparam int F_SYS_RATE_A = 3;
	localparam int F_BAT_RATE_I = 5;
	localparam int F_SYS_RATE_I = 6;
	// control B fields
	localparam int F_DIE_RATE_A = 0;
	localparam int F_DIE_RATE_I = 2;
	// throttle behaviour fields
	localparam int F_THR_ZB_EN = 0;
	localparam int F_THR_ZA_EN = 1;
	localparam int F_THR_ST = 2;
	// zone B control fields
	localparam int F_ZB_DIS_EN = 0;
	localparam int F_ZB_STICKY = 1;
	localparam int F_ZB_CLEAR = 2;
	localparam int F_ZB_IRQ = 3;
	localparam int F_SUM_IRQ = 4;
	// alert high byte fields
	localparam int F_HYST = 2;
	localparam int F_AEN = 6;
	localparam int F_APOL = 7;
	// timing
	localparam int FILT_US = 100;
	localparam int RELEASE_US = 500;
	localparam int FILT_CYC = FILT_US * CLK_MHZ;
	localparam int RELEASE_CYC = RELEASE_US * CLK_MHZ;
	localparam int TICK_MS_CYC = 1000 * CLK_MHZ;
	localparam int SEC_MS = 1000;
	localparam logic [5:0] PERIOD_1S = 6'h01;
	localparam logic [5:0] PERIOD_4S = 6'h04;
	localparam logic [5:0] PERIOD_32S = 6'h20;
	localparam int NCH = 3;
	localparam int CH_SYS = 0;
	localparam int CH_BAT = 1;
	localparam int CH_DIE = 2;

	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_IDLE = 2'b10,
		PWR_ON = 2'b11
	} power_e;

	typedef struct packed {
		logic underVolt;
		logic overVolt;
		logic supplyValid;
		logic dieWarm;
		logic dieHot;
		logic zoneA;
		logic zoneB;
	} flags_s;

	typedef struct packed {
		logic valid;
		logic [1:0] channel;
		logic [9:0] code;
	} sample_s;
endpackage : supply_thermal_supervisor_pkg

// >>> verif/adc_model.sv
// converter stand-in answering each conversion request with one result pulse
// assumes requests are single-cycle pulses and the bench supplies the code
`timescale 1ns/100ps
module adc_model
	import supply_thermal_supervisor_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request and stimulus
	input wire logic convStart,
	input wire logic [1:0] convChannel,
	input wire logic [9:0] codeIn,
	input wire logic slow,
	// result
	output sample_s sample
);
	logic [3:0] waitCnt;
	logic [1:0] chan;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waitCnt <= 4'h0;
			chan <= 2'h0;
			sample <= '0;
		end else begin
			// result fields churn while not valid so no stale value passes
			sample <= {1'b0, ~sample.channel, ~sample.code};
			if (convStart) begin
				waitCnt <= slow ? 4'h9 : 4'h1;
				chan <= convChannel;
			end else if (waitCnt != 4'h0) begin
				waitCnt <= waitCnt - 4'h1;
				if (waitCnt == 4'h1) begin
					sample <= {1'b1, chan, codeIn};
				end
			end
		end
	end
endmodule : adc_model

// >>> verif/supply_thermal_supervisor_bench.sv
// self-checking bench for the supply and thermal supervisor
// assumes shortened filters and a converter model on the far side
`timescale 1ns/100ps
module supply_thermal_supervisor_bench;
	import supply_thermal_supervisor_pkg::*;
	localparam int FILT = 8;
	localparam int REL = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	power_e powerState = PWR_ON;
	flags_s flags = 7'h10;
	logic convStart;
	logic [1:0] convChannel;
	sample_s sample;
	logic [9:0] code = 10'h3ff;
	logic slow = 1'b0;
	logic throttleN;
	logic zbDis;
	logic irq;
	logic shutdown;
	logic [7:0] tmp;
	int errCount = 0;
	int nTests = 0;
	always #4 clk = ~clk;
	supply_thermal_supervisor #(.FILT_CYCLES(FILT), .RELEASE_CYCLES(REL), .TICK_CYCLES(2))
		supply_thermal_supervisor_i (.clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .powerState(powerState), .flags(flags),
		.convStart(convStart), .convChannel(convChannel), .sample(sample), .processor_throttle_n(throttleN),
		.zone_b_disable_output(zbDis), .supply_monitor_irq(irq), .shutdownReq(shutdown));
	adc_model adc_model_i (.clk(clk), .rst(rst), .convStart(convStart), .convChannel(convChannel),
		.codeIn(code), .slow(slow), .sample(sample));
	// reserved top bit of the second alert high byte reads zero
	function automatic logic [7:0] rwMask(input logic [7:0] a);
		return (a == OFF_SYS0_A1H) ? 8'h7f : 8'hff;
	endfunction : rwMask
	function automatic logic hot(input logic [9:0] c, input logic [9:0] thr);
		return c < thr;
	endfunction : hot
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWrite = 1'b0;
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(negedge clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clk);
		regRead = 1'b0;
		chk(regRdata & mask, exp);
	endtask : rdChk
	task automatic zb(input logic lvl, input logic [7:0] cfg, input logic expDis, input logic expThr);
		@(negedge clk);
		flags.zoneB = lvl;
		hold(3);
		chk({5'h00, irq, zbDis, ~throttleN}, {5'h00, 1'b1, expDis, expThr});
		rdChk(OFF_ZONE_B_CTL, 8'h18, 8'h18);
		wr(OFF_ZONE_B_CTL, cfg | 8'h18);
		hold(1);
		chk({7'h00, irq}, 8'h00);
	endtask : zb
	task automatic testDone();
		$display("comparisons %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : testDone
	initial begin
		repeat (40000) @(posedge clk);
		errCount++;
		testDone();
	end
	initial begin
		void'($urandom(32'h5861));
		hold(5);
		rst = 1'b0;
		rdChk(OFF_MON_CTL_A, 8'hff, RST_MON_CTL_A);
		rdChk(OFF_MON_CTL_B, 8'hff, RST_MON_CTL_B);
		rdChk(OFF_THROT_BEH, 8'hff, 8'h04);
		for (int i = 0; i < 7; i++) begin
			rdChk(OFF_SYS0_A0H + 8'(i), 8'hff, RST_ZERO);
			tmp = 8'($urandom);
			wr(OFF_SYS0_A0H + 8'(i), tmp);
			rdChk(OFF_SYS0_A0H + 8'(i), 8'hff, tmp & rwMask(OFF_SYS0_A0H + 8'(i)));
		end
		wr(8'h50, 8'hff);
		rdChk(8'h50, 8'hff, 8'h00);
		wr(OFF_THROT_BEH, 8'h01);
		wr(OFF_ZONE_B_CTL, 8'h01);
		zb(1'b1, 8'h01, 1'b1, 1'b1);
		zb(1'b0, 8'h01, 1'b0, 1'b0);
		zb(1'b1, 8'h03, 1'b1, 1'b1);
		zb(1'b0, 8'h03, 1'b1, 1'b1);
		wr(OFF_ZONE_B_CTL, 8'h07);
		hold(3);
		chk({6'h00, zbDis, throttleN}, 8'h01);
		wr(OFF_THROT_BEH, 8'h00);
		zb(1'b1, 8'h01, 1'b1, 1'b0);
		zb(1'b0, 8'h01, 1'b0, 1'b0);
		wr(OFF_THROT_BEH, 8'h02);
		flags.zoneA = 1'b1;
		hold(3);
		chk({7'h00, throttleN}, 8'h00);
		flags.zoneA = 1'b0;
		hold(3);
		chk({7'h00, throttleN}, 8'h01);
		wr(OFF_THROT_BEH, 8'h00);
		flags.dieWarm = 1'b1;
		hold(FILT - 2);
		flags.dieWarm = 1'b0;
		hold(4);
		chk({7'h00, throttleN}, 8'h01);
		flags.dieWarm = 1'b1;
		hold(FILT + 4);
		rdChk(OFF_THROT_BEH, 8'h04, 8'h00);
		chk({7'h00, throttleN}, 8'h00);
		flags.dieWarm = 1'b0;
		hold(REL - 4);
		chk({7'h00, throttleN}, 8'h00);
		hold(10);
		chk({7'h00, throttleN}, 8'h01);
		wr(OFF_SENSOR_EN, 8'h01);
		wr(OFF_MON_CTL_B, 8'h00);
		wr(OFF_SYS0_A0L, 8'h00);
		wr(OFF_SYS0_A0H, 8'hd2);
		wr(OFF_SYS0_CRIT, 8'hc0);
		wr(OFF_MON_CTL_A, 8'h09);
		for (int k = 0; k < 2; k++) begin
			code = (k == 1) ? 10'h300 + 10'($urandom % 256) : 10'h1ff - 10'($urandom % 256);
			slow = k[0];
			for (int n = 0; n < 5000 && convStart !== 1'b1; n++) begin
				@(negedge clk);
			end
			chk({5'h00, convStart, convChannel}, {6'h01, 2'(CH_SYS)});
			hold(15);
			rdChk(OFF_STATUS, 8'h44, {1'b0, hot(code, 10'h180), 3'b000, hot(code, 10'h200), 2'b00});
			chk({7'h00, throttleN}, {7'h00, ~hot(code, 10'h200)});
		end
		powerState = PWR_OFF;
		tmp = 8'h00;
		repeat (4500) begin
			@(negedge clk);
			tmp = tmp + 8'(convStart);
		end
		chk(tmp, 8'h00);
		powerState = PWR_ON;
		wr(OFF_ZONE_B_CTL, 8'h18);
		flags.underVolt = 1'b1;
		hold(FILT - 3);
		flags.underVolt = 1'b0;
		hold(4);
		chk({7'h00, shutdown}, 8'h00);
		flags.underVolt = 1'b1;
		flags.supplyValid = 1'b0;
		hold(FILT + 4);
		chk({6'h00, shutdown, irq}, 8'h02);
		flags.underVolt = 1'b0;
		hold(6);
		chk({7'h00, shutdown}, 8'h01);
		flags.supplyValid = 1'b1;
		hold(4);
		chk({7'h00, shutdown}, 8'h00);
		flags.overVolt = 1'b1;
		hold(FILT + 24);
		chk({6'h00, shutdown, irq}, 8'h02);
		flags.overVolt = 1'b0;
		hold(4);
		chk({7'h00, shutdown}, 8'h00);
		flags.dieHot = 1'b1;
		hold(FILT + 4);
		chk({7'h00, shutdown}, 8'h01);
		flags.dieHot = 1'b0;
		rst = 1'b1;
		hold(2);
		rst = 1'b0;
		hold(2);
		chk({6'h00, shutdown, throttleN}, 8'h01);
		testDone();
	end
endmodule : supply_thermal_supervisor_bench

// >>> verif/supply_thermal_supervisor_sva.sv
// port assertions for the supply and thermal supervisor
// assumes single clock domain with asynchronous active-high reset
`timescale 1ns/100ps
module supply_thermal_supervisor_sva
	import supply_thermal_supervisor_pkg::*;
#(
	parameter int FILT_CYCLES = FILT_CYC,
	parameter int RELEASE_CYCLES = RELEASE_CYC,
	parameter int TICK_CYCLES = TICK_MS_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	// platform and converter
	input wire power_e powerState,
	input wire flags_s flags,
	input wire logic convStart,
	input wire logic [1:0] convChannel,
	input wire sample_s sample,
	// outputs
	input wire logic processor_throttle_n,
	input wire logic zone_b_disable_output,
	input wire logic supply_monitor_irq,
	input wire logic shutdownReq
);
	logic [7:0] faultCnt;
	logic [7:0] warmCnt;
	logic [7:0] coolCnt;
	function automatic logic [7:0] sat(input logic [7:0] c);
		return (c == 8'hff) ? c : c + 8'h01;
	endfunction : sat
	// saturating run lengths, long enough for the shortened filters only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			faultCnt <= 8'h00;
			warmCnt <= 8'h00;
			coolCnt <= 8'h00;
		end else begin
			faultCnt <= (flags.underVolt || flags.overVolt || flags.dieHot) ? sat(faultCnt) : 8'h00;
			warmCnt <= flags.dieWarm ? sat(warmCnt) : 8'h00;
			coolCnt <= flags.dieWarm ? 8'h00 : sat(coolCnt);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_zb_irq; $changed(flags.zoneB) |=> supply_monitor_irq; endproperty
	a_zb_irq: assert property (p_zb_irq) else $error("zone B change without interrupt");
	property p_zb_dis;
		$rose(zone_b_disable_output) |-> $past(flags.zoneB) || $past(regWrite && regAddr == OFF_ZONE_B_CTL, 2);
	endproperty
	a_zb_dis: assert property (p_zb_dis) else $error("disable output without zone B");
	property p_no_fault_irq;
		(flags.underVolt || flags.overVolt) && $stable(flags.zoneB) && !supply_monitor_irq && !sample.valid
			|=> !supply_monitor_irq;
	endproperty
	a_no_fault_irq: assert property (p_no_fault_irq) else $error("interrupt on supply fault");
	property p_fault; faultCnt >= FILT_CYCLES + 3 |-> shutdownReq; endproperty
	a_fault: assert property (p_fault) else $error("fault not shut down");
	property p_filter; $rose(shutdownReq) |-> faultCnt >= FILT_CYCLES; endproperty
	a_filter: assert property (p_filter) else $error("shutdown before filter time");
	property p_ov_hold; flags.overVolt && shutdownReq |=> shutdownReq; endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("left off during over-voltage");
	property p_uv_hold; shutdownReq && !flags.supplyValid |=> shutdownReq; endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("left off without valid supply");
	property p_warm; warmCnt >= FILT_CYCLES + 3 |-> !processor_throttle_n; endproperty
	a_warm: assert property (p_warm) else $error("pre-alarm not throttling");
	property p_release; $rose(processor_throttle_n) |-> coolCnt >= RELEASE_CYCLES; endproperty
	a_release: assert property (p_release) else $error("throttle released early");
	property p_status;
		regRead && regAddr == OFF_THROT_BEH |=> regRdata[F_THR_ST] == $past(processor_throttle_n);
	endproperty
	a_status: assert property (p_status) else $error("throttle status bit wrong");
	property p_conv; convStart |=> !convStart; endproperty
	a_conv: assert property (p_conv) else $error("conversion request too long");
	property p_off; powerState == PWR_OFF |=> !convStart; endproperty
	a_off: assert property (p_off) else $error("polling while off");
endmodule : supply_thermal_supervisor_sva
bind supply_thermal_supervisor supply_thermal_supervisor_sva #(.FILT_CYCLES(FILT_CYCLES),
	.RELEASE_CYCLES(RELEASE_CYCLES), .TICK_CYCLES(TICK_CYCLES)) sva_i (.clk(clk), .rst(rst),
	.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
	.powerState(powerState), .flags(flags), .convStart(convStart), .convChannel(convChannel), .sample(sample),
	.processor_throttle_n(processor_throttle_n), .zone_b_disable_output(zone_b_disable_output),
	.supply_monitor_irq(supply_monitor_irq), .shutdownReq(shutdownReq));
